// ### rtl/sps_status.v
`timescale 1ns/1ps
`include "sps_map.vh"

module sps_status
(
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // Register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Receiver events
  input  wire        i_rx_char_done,
  input  wire [8:0]  i_rx_char,
  input  wire        i_break_event,
  input  wire        i_overrun_event,
  input  wire        i_frame_event,
  input  wire        i_parity_event,
  input  wire        i_timeout,
  input  wire        i_iteration,
  input  wire        i_not_acknowledged_flag,
  // Transmitter side
  input  wire        i_tx_shift_take,
  input  wire        i_tx_shift_busy,
  input  wire        i_break_started,
  // DMA channel signals
  input  wire        i_rx_dma_done,
  input  wire        i_tx_dma_done,
  input  wire        i_tx_dma_empty,
  input  wire        i_rx_dma_full,
  // Modem line
  input  wire        i_cts,
  // Outputs toward transmitter and core
  output reg  [8:0]  o_tx_char,
  output reg         o_tx_char_valid,
  output reg         o_rx_enable,
  output reg         o_tx_enable,
  output reg         o_break_request,
  output reg         o_irq
);

  reg  [31:0] irq_mask;
  reg  [8:0]  rx_hold;
  reg         rx_have;
  reg         tx_full;
  reg         cts_prev;
  reg         rx_dma_done_r;
  reg         tx_dma_done_r;
  reg         tx_dma_empty_r;
  reg         rx_dma_full_r;
  wire        f_break;
  wire        f_overrun;
  wire        f_frame;
  wire        f_parity;
  wire        f_clear_to_send_change_flag;
  wire        clr_status;
  wire        flags_read;
  reg  [31:0] next_flags;
  reg  [31:0] next_rdata;

  function wire_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      wire_hit = (addr == off);
    end
  endfunction

  assign clr_status = i_wr && wire_hit(i_addr, `SPS_OFF_CONTROL) && i_wdata[`SPS_C_CLR_STAT];
  assign flags_read = i_rd && wire_hit(i_addr, `SPS_OFF_FLAGS);

  // Mask and control register
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      irq_mask    <= `SPS_MASK_RESET;
      o_rx_enable <= 1'b0;
      o_tx_enable <= 1'b0;
    end
    else if (i_wr)
    begin
      if (wire_hit(i_addr, `SPS_OFF_IRQ_ENABLE))
        irq_mask <= irq_mask | (i_wdata & `SPS_MASK_VALID);
      if (wire_hit(i_addr, `SPS_OFF_IRQ_DISABLE))
        irq_mask <= irq_mask & ~(i_wdata & `SPS_MASK_VALID);
      if (wire_hit(i_addr, `SPS_OFF_CONTROL))
      begin
        o_rx_enable <= i_wdata[`SPS_C_RX_EN];
        o_tx_enable <= i_wdata[`SPS_C_TX_EN];
      end
    end
  end

  // Receive holding register; held char survives disable
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rx_hold <= 9'h000;
      rx_have <= 1'b0;
    end
    else if (i_rx_char_done)
    begin
      rx_hold <= i_rx_char;
      rx_have <= 1'b1;
    end
    else if (i_rd && wire_hit(i_addr, `SPS_OFF_RX_CHAR))
      rx_have <= 1'b0;
  end

  // Transmit holding register and break request
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_tx_char       <= 9'h000;
      tx_full         <= 1'b0;
      o_tx_char_valid <= 1'b0;
      o_break_request <= 1'b0;
    end
    else
    begin
      if (i_wr && wire_hit(i_addr, `SPS_OFF_TX_HOLD) && o_tx_enable)
      begin
        o_tx_char <= i_wdata[8:0];
        tx_full   <= 1'b1;
      end
      else if (i_tx_shift_take)
        tx_full <= 1'b0;
      o_tx_char_valid <= tx_full && o_tx_enable;
      if (i_wr && wire_hit(i_addr, `SPS_OFF_CONTROL) && i_wdata[`SPS_C_BRK_GO])
        o_break_request <= 1'b1;
      else if (i_break_started ||
               (i_wr && wire_hit(i_addr, `SPS_OFF_CONTROL) && i_wdata[`SPS_C_STPBRK]))
        o_break_request <= 1'b0;
    end
  end

  // Sticky error flags and CTS change flag
  sps_sticky u_break
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_break_event),
    .i_clr      (clr_status),
    .o_flag     (f_break)
  );

  sps_sticky u_overrun
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_overrun_event),
    .i_clr      (clr_status),
    .o_flag     (f_overrun)
  );

  sps_sticky u_frame
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_frame_event),
    .i_clr      (clr_status),
    .o_flag     (f_frame)
  );

  sps_sticky u_parity
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_parity_event),
    .i_clr      (clr_status),
    .o_flag     (f_parity)
  );

  sps_sticky u_clear_to_send_change_flag
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_cts != cts_prev),
    .i_clr      (flags_read),
    .o_flag     (f_clear_to_send_change_flag)
  );

  // CTS history and DMA signal registers
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      // Track the pin in reset too, so no false change follows reset
      cts_prev       <= i_cts;
      rx_dma_done_r  <= 1'b0;
      tx_dma_done_r  <= 1'b0;
      tx_dma_empty_r <= 1'b0;
      rx_dma_full_r  <= 1'b0;
    end
    else
    begin
      cts_prev       <= i_cts;
      rx_dma_done_r  <= i_rx_dma_done;
      tx_dma_done_r  <= i_tx_dma_done;
      tx_dma_empty_r <= i_tx_dma_empty;
      rx_dma_full_r  <= i_rx_dma_full;
    end
  end

  // Status word
  always @*
  begin
    next_flags = 32'h00000000;
    next_flags[`SPS_B_RX_READY] = rx_have && o_rx_enable;
    next_flags[`SPS_B_TX_READY] = !tx_full && !o_break_request && o_tx_enable;
    next_flags[`SPS_B_BREAK]   = f_break;
    next_flags[`SPS_B_RXDONE]  = rx_dma_done_r;
    next_flags[`SPS_B_TXDONE]  = tx_dma_done_r;
    next_flags[`SPS_B_OVERRUN] = f_overrun;
    next_flags[`SPS_B_FRAME]   = f_frame;
    next_flags[`SPS_B_PARITY]  = f_parity;
    next_flags[`SPS_B_TIMEOUT] = i_timeout;
    next_flags[`SPS_B_TXIDLE]  = o_tx_enable && !tx_full && !i_tx_shift_busy;
    next_flags[`SPS_B_ITER]    = i_iteration;
    next_flags[`SPS_B_TX_EMPTY] = tx_dma_empty_r;
    next_flags[`SPS_B_RX_FULL]  = rx_dma_full_r;
    next_flags[`SPS_B_NOT_ACKNOWLEDGED_FLAG]    = i_not_acknowledged_flag;
    next_flags[`SPS_B_CTS_CHG]  = f_clear_to_send_change_flag;
    next_flags[`SPS_B_CTS]     = cts_prev;
  end

  // Read mux
  always @*
  begin
    next_rdata = 32'h00000000;
    case (i_addr)
      `SPS_OFF_IRQ_MASK: next_rdata = irq_mask;
      `SPS_OFF_FLAGS:    next_rdata = next_flags;
      `SPS_OFF_CONTROL:  next_rdata = {30'h00000000, o_tx_enable, o_rx_enable};
      `SPS_OFF_RX_CHAR:  next_rdata = {23'h000000, rx_hold};
      default:           next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h00000000;
      o_irq   <= 1'b0;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : 32'h00000000;
      o_irq   <= |(next_flags & irq_mask & `SPS_MASK_VALID);
    end
  end

endmodule // sps_status

// ### rtl/sps_sticky.v
`timescale 1ns/1ps
// Sticky flag: set wins over clear
module sps_sticky
(
  // Clock and reset
  input  wire i_core_clk,
  input  wire i_rst,
  // Events
  input  wire i_set,
  input  wire i_clr,
  // Flag
  output reg  o_flag
);

  always @(posedge i_core_clk)
  begin
    if (i_rst)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clr)
      o_flag <= 1'b0;
  end

endmodule // sps_sticky

// ### shared/sps_map.vh
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// Register byte addresses
`define SPS_ADDR_W          8
`define SPS_OFF_IRQ_ENABLE  8'h00
`define SPS_OFF_IRQ_DISABLE 8'h04
`define SPS_OFF_IRQ_MASK    8'h08
`define SPS_OFF_FLAGS       8'h0c
`define SPS_OFF_CONTROL     8'h10
`define SPS_OFF_RX_CHAR     8'h14
`define SPS_OFF_TX_HOLD     8'h18

// Status and mask bit positions
`define SPS_B_RX_READY 0
`define SPS_B_TX_READY 1
`define SPS_B_BREAK    2
`define SPS_B_RXDONE   3
`define SPS_B_TXDONE   4
`define SPS_B_OVERRUN  5
`define SPS_B_FRAME    6
`define SPS_B_PARITY   7
`define SPS_B_TIMEOUT  8
`define SPS_B_TXIDLE   9
`define SPS_B_ITER     10
`define SPS_B_TX_EMPTY 11
`define SPS_B_RX_FULL  12
`define SPS_B_NOT_ACKNOWLEDGED_FLAG     13
`define SPS_B_CTS_CHG  19
`define SPS_B_CTS      23

// Valid mask bits 0..13 and 19
`define SPS_MASK_VALID 32'h00083fff
`define SPS_MASK_RESET 32'h00000000

// Control register bits
`define SPS_C_RX_EN    0
`define SPS_C_TX_EN    1
`define SPS_C_CLR_STAT 2
`define SPS_C_BRK_GO   3
`define SPS_C_STPBRK   4

`endif

// ### verification/sps_status_asserts.sv
`timescale 1ns/1ps
`include "sps_map.vh"
module sps_status_asserts
(
  // Clock, reset, register port
  input wire        i_core_clk, i_rst, i_rd, i_wr,
  input wire [7:0]  i_addr,
  input wire [31:0] o_rdata,
  // Events and state
  input wire        i_rx_char_done, i_break_event, i_rx_dma_done, i_cts,
  input wire        o_rx_enable, o_tx_enable, o_tx_char_valid, o_break_request
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire rf = i_rd && i_addr == `SPS_OFF_FLAGS;
  wire tb = o_tx_char_valid || o_break_request || !o_tx_enable;
  sequence s_rx; i_rx_char_done && o_rx_enable ##1 !i_rd ##1 rf && o_rx_enable; endsequence
  sequence s_brk; i_break_event ##1 !i_wr [*2] ##1 rf; endsequence
  sequence s_cts; $changed(i_cts) && !$past(i_rst) ##1 !i_rd [*2] ##1 rf; endsequence
  property p_rb;
    i_rd && i_addr == `SPS_OFF_IRQ_MASK |=> !(o_rdata & ~`SPS_MASK_VALID);
  endproperty
  property p_rxoff; rf && !o_rx_enable |=> !o_rdata[0]; endproperty
  property p_rx; s_rx |=> o_rdata[0]; endproperty
  property p_txbusy; rf && tb |=> !o_rdata[1]; endproperty
  property p_txfree; rf && !tb |=> o_rdata[1]; endproperty
  property p_brk; s_brk |=> o_rdata[2]; endproperty
  property p_dma; rf && !$past(i_rst) |=> o_rdata[3] == $past(i_rx_dma_done, 2); endproperty
  property p_cts; s_cts |=> o_rdata[19]; endproperty
  a_rb: assert property (p_rb) else $error("mask bits");
  a_rxoff: assert property (p_rxoff) else $error("rx off");
  a_rx: assert property (p_rx) else $error("rx ready");
  a_txbusy: assert property (p_txbusy) else $error("tx busy");
  a_txfree: assert property (p_txfree) else $error("tx free");
  a_brk: assert property (p_brk) else $error("break");
  a_dma: assert property (p_dma) else $error("rx dma");
  a_cts: assert property (p_cts) else $error("cts");
endmodule // sps_status_asserts

bind sps_status sps_status_asserts u_chk (.*);

// ### verification/sps_status_tb.sv
`timescale 1ns/1ps
`include "sps_map.vh"
module sps_status_tb;
  reg         clk = 0, rst = 1, wr = 0, rd = 0, cd = 0, brk = 0, ovr = 0, frm = 0, par = 0;
  reg         take = 0, bst = 0, rdd = 0, tdd = 0, cts = 0;
  reg  [7:0]  a = 0;
  reg  [31:0] wd = 0;
  reg  [8:0]  ch = 0;
  wire [31:0] rdat;
  wire        irq;
  wire [8:0]  txc;
  wire        txv, rxe, txe, brq;
  integer     fail_count = 0, total_checks = 0;
  localparam [7:0]  fl = `SPS_OFF_FLAGS, cr = `SPS_OFF_CONTROL, mk = `SPS_OFF_IRQ_MASK;
  localparam [7:0]  en = `SPS_OFF_IRQ_ENABLE, di = `SPS_OFF_IRQ_DISABLE;
  localparam [31:0] al = 32'hffffffff;
  always #20 clk = ~clk;
  sps_status u_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_rx_char_done(cd), .i_rx_char(ch), .i_break_event(brk),
    .i_overrun_event(ovr), .i_frame_event(frm), .i_parity_event(par), .i_timeout(1'b0),
    .i_iteration(1'b0), .i_not_acknowledged_flag(1'b0), .i_tx_shift_take(take), .i_tx_shift_busy(1'b0),
    .i_break_started(bst), .i_rx_dma_done(rdd), .i_tx_dma_done(tdd), .i_tx_dma_empty(tdd),
    .i_rx_dma_full(rdd), .i_cts(cts), .o_tx_char(txc), .o_tx_char_valid(txv),
    .o_rx_enable(rxe), .o_tx_enable(txe), .o_break_request(brq), .o_irq(irq));
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task w(input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      wr <= 1;
      a <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 0;
    end
  endtask
  // Read, then compare the masked word
  task rc(input [7:0] ad, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk);
      rd <= 1;
      a <= ad;
      @(posedge clk);
      rd <= 0;
      #1 total_checks = total_checks + 1;
      if ((rdat & m) !== e)
      begin
        fail_count = fail_count + 1;
        $display("FAIL reg %h bits %h exp %h got %h", ad, m, e, rdat & m);
      end
    end
  endtask
  task cv(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("FAIL %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task ci(input e);
    begin
      cyc(2);
      #1 total_checks = total_checks + 1;
      if (irq !== e)
      begin
        fail_count = fail_count + 1;
        $display("FAIL irq exp %b got %b", e, irq);
      end
    end
  endtask
  task t_mask;
    begin
      rc(mk, al, 32'h0);
      w(en, al);
      w(mk, 32'h0);
      rc(mk, al, `SPS_MASK_VALID);
      w(di, 32'h00080001);
      rc(mk, al, 32'h00003ffe);
      w(di, al);
      rc(8'hfc, al, 32'h0);
      $display("mask test end");
    end
  endtask
  task t_rx;
    begin
      w(cr, 32'h3);
      ch <= 9'h1a5;
      @(posedge clk) cd <= 1;
      @(posedge clk) cd <= 0;
      rc(fl, 32'h1, 32'h1);
      w(cr, 32'h2);
      rc(fl, 32'h1, 32'h0);
      cv("rx_en", 32'h0, rxe);
      cv("tx_en", 32'h1, txe);
      w(cr, 32'h3);
      rc(fl, 32'h1, 32'h1);
      rc(`SPS_OFF_RX_CHAR, 32'h1ff, 32'h1a5);
      rc(fl, 32'h1, 32'h0);
      $display("rx test end");
    end
  endtask
  task t_tx;
    begin
      w(cr, 32'h0);
      rc(fl, 32'h2, 32'h0);
      w(cr, 32'h2);
      rc(fl, 32'h2, 32'h2);
      w(`SPS_OFF_TX_HOLD, 32'h15a);
      rc(fl, 32'h2, 32'h0);
      cv("tx_char", 32'h15a, txc);
      cv("tx_valid", 32'h1, txv);
      @(posedge clk) take <= 1;
      @(posedge clk) take <= 0;
      rc(fl, 32'h2, 32'h2);
      cv("tx_valid", 32'h0, txv);
      w(cr, 32'ha);
      rc(fl, 32'h2, 32'h0);
      cv("brk_req", 32'h1, brq);
      @(posedge clk) bst <= 1;
      @(posedge clk) bst <= 0;
      rc(fl, 32'h2, 32'h2);
      cv("brk_req", 32'h0, brq);
      $display("tx test end");
    end
  endtask
  task t_stk;
    begin
      @(posedge clk) {brk, ovr, frm, par} <= 4'hf;
      @(posedge clk) {brk, ovr, frm, par} <= 4'h0;
      cyc(1);
      rc(fl, 32'he4, 32'he4);
      rc(fl, 32'he4, 32'he4);
      w(cr, 32'h6);
      rc(fl, 32'he4, 32'h0);
      $display("sticky test end");
    end
  endtask
  task t_cts;
    begin
      @(posedge clk) {cts, rdd, tdd} <= 3'h7;
      cyc(2);
      rc(fl, 32'h881818, 32'h881818);
      rc(fl, 32'h881818, 32'h801818);
      @(posedge clk) {rdd, tdd} <= 2'h0;
      cyc(2);
      rc(fl, 32'h001818, 32'h0);
      $display("cts test end");
    end
  endtask
  task t_irq;
    begin
      w(en, 32'h80);
      ci(0);
      @(posedge clk) par <= 1;
      @(posedge clk) par <= 0;
      ci(1);
      w(di, 32'h80);
      ci(0);
      w(en, 32'h80);
      ci(1);
      w(cr, 32'h6);
      ci(0);
      $display("irq test end");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    cyc(6);
    rst <= 0;
    t_mask;
    t_rx;
    t_tx;
    t_stk;
    t_cts;
    t_irq;
    report_and_stop;
  end
  initial
  begin
    cyc(2000);
    fail_count = fail_count + 1;
    report_and_stop;
  end
endmodule // sps_status_tb
